// file: shared/pcmvs_defines.vh
// Constants for the PCM voice serial port: register map, field layout,
// reset values and timing counts. Definitions only.
`ifndef PCMVS_DEFINES_VH
`define PCMVS_DEFINES_VH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define PCMVS_ADDR_W      3
`define PCMVS_REG_CTRL    3'h0
`define PCMVS_REG_TXDATA  3'h1
`define PCMVS_REG_RXDATA  3'h2
`define PCMVS_REG_STATUS  3'h3

// ----------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------
`define PCMVS_CTRL_EN     0
`define PCMVS_CTRL_MST    1
`define PCMVS_CTRL_LONG   2
`define PCMVS_CTRL_FMT    4
`define PCMVS_CTRL_PAD    6
`define PCMVS_CTRL_BSEL   8
`define PCMVS_CTRL_GAIN   12
`define PCMVS_CTRL_RST    16'h0000
`define PCMVS_TXDATA_RST  16'h0000

// Sample formats and pad modes
`define PCMVS_FMT_8       2'h0
`define PCMVS_FMT_13      2'h1
`define PCMVS_PAD_NONE    2'h0
`define PCMVS_PAD_SIGN    2'h1
`define PCMVS_PAD_ZERO    2'h2
`define PCMVS_PAD_GAIN    2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCMVS_CLK_HZ      40000000
`define PCMVS_FRAME_HZ    8000
`define PCMVS_BCLK0_HZ    64000
`define PCMVS_BCLK1_HZ    128000
`define PCMVS_BCLK2_HZ    256000
`define PCMVS_BCLK3_HZ    512000
// Half periods round down so each clock phase stays as short as allowed
`define PCMVS_HALF0 (`PCMVS_CLK_HZ / (2 * `PCMVS_BCLK0_HZ))
`define PCMVS_HALF1 (`PCMVS_CLK_HZ / (2 * `PCMVS_BCLK1_HZ))
`define PCMVS_HALF2 (`PCMVS_CLK_HZ / (2 * `PCMVS_BCLK2_HZ))
`define PCMVS_HALF3 (`PCMVS_CLK_HZ / (2 * `PCMVS_BCLK3_HZ))
// Bit clocks per frame
`define PCMVS_FBITS0 (`PCMVS_BCLK0_HZ / `PCMVS_FRAME_HZ)
`define PCMVS_FBITS1 (`PCMVS_BCLK1_HZ / `PCMVS_FRAME_HZ)
`define PCMVS_FBITS2 (`PCMVS_BCLK2_HZ / `PCMVS_FRAME_HZ)
`define PCMVS_FBITS3 (`PCMVS_BCLK3_HZ / `PCMVS_FRAME_HZ)

`endif

// file: design/pcmvs_sync.v
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps

module pcmvs_sync #(
  parameter W = 3
) (
  input  wire         clock,   // System clock
  input  wire         arst_n,  // Async reset, active low
  input  wire [W-1:0] d,       // Asynchronous levels
  output reg  [W-1:0] q        // Synchronised levels
);

  reg [W-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// file: design/pcmvs_bclk_gen.v
// Bit clock divider for master role: produces the bit clock level.
// Assumes a 40 MHz system clock; half periods come from the header.
`timescale 1ns/1ps
`include "pcmvs_defines.vh"

module pcmvs_bclk_gen (
  input  wire       clock,   // System clock
  input  wire       arst_n,  // Async reset, active low
  input  wire       run,     // Divider runs while high
  input  wire [1:0] sel,     // Rate: 64/128/256/512 kHz
  output reg        bclk_q   // Generated bit clock
);

  reg  [8:0]  cnt_q;
  reg  [31:0] half;
  wire        wrap;

  // Half period in system clocks for the chosen rate
  always @* begin
    case (sel)
      2'h0:    half = `PCMVS_HALF0;
      2'h1:    half = `PCMVS_HALF1;
      2'h2:    half = `PCMVS_HALF2;
      default: half = `PCMVS_HALF3;
    endcase
  end

  // Wrap also when a rate change leaves the count beyond the new end
  assign wrap = ({23'h0, cnt_q} >= half - 32'h1);

  // Count half periods and toggle the clock
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 9'h000;
      bclk_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= 9'h000;
      bclk_q <= 1'b0;
    end else if (wrap) begin
      cnt_q  <= 9'h000;
      bclk_q <= ~bclk_q;
    end else begin
      cnt_q  <= cnt_q + 9'h001;
    end
  end

endmodule

// file: design/pcmvs_port.v
// PCM voice serial port: one sample per frame each way to an audio codec,
// with an Avalon-MM register slave using waitrequest.
// Assumes pins from the codec are asynchronous to clock (40 MHz).
//
// Notes on behaviour
// [R01] Master or slave role, software selectable
// [R02] Frame pulse starts each slot transfer
// [R03] Long framing: data starts at pulse rise
// [R04] Short framing: data starts at pulse fall
// [R05] Long or short framing is programmable
// [R06] 8-bit companded, 13 or 16-bit linear formats
// [R07] Spare bits sign extended or zero padded
// [R08] Optional 3-bit gain in 13-bit spare bits
// [R09] Master bit clock 64/128/256/512 kHz
// [R10] Master frame pulse at 8 kHz
// [R11] Slave clocks come from codec side
// [R12] One slot per frame each direction
// [R13] Outgoing bits launched after bit clock rise
// [R14] Incoming bits sampled on bit clock fall
// [R15] Master frame pulse rises after clock rise
// [R16] Most significant bit first, sign replicates top
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "pcmvs_defines.vh"

module pcmvs_port (
  input  wire        clock,             // System clock, 40 MHz
  input  wire        arst_n,            // Async reset, active low
  input  wire [2:0]  avs_address,       // Word address
  input  wire        avs_read,          // Read request
  input  wire        avs_write,         // Write request
  input  wire [31:0] avs_writedata,     // Write data
  input  wire [3:0]  avs_byteenable,    // Byte lanes
  output reg  [31:0] avs_readdata,      // Read data
  output wire        avs_waitrequest,   // Stall request
  input  wire        pcm_bclk_i,        // Bit clock pin in
  output wire        pcm_bclk_o,        // Bit clock pin out
  output wire        pcm_bclk_oe,       // Bit clock drive enable
  input  wire        frame_pulse_i,     // Frame pulse pin in
  output wire        frame_pulse_o,     // Frame pulse pin out
  output wire        frame_pulse_oe,    // Frame pulse drive enable
  output wire        pcm_tx,            // Data to codec
  input  wire        pcm_rx             // Data from codec
);

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  reg  [15:0] ctrl_q;
  reg  [15:0] txdata_q;
  reg  [15:0] rxdata_q;
  reg         rx_full_q;
  reg         tx_taken_q;
  reg  [7:0]  frames_q;
  reg         ack_q;
  wire        req;
  wire        acc;
  wire        wr_ctrl;
  wire        wr_tx;
  wire        rd_rx;

  wire        en    = ctrl_q[`PCMVS_CTRL_EN];
  wire        mst   = ctrl_q[`PCMVS_CTRL_MST];
  wire        lng   = ctrl_q[`PCMVS_CTRL_LONG];
  wire [1:0]  fmt   = ctrl_q[`PCMVS_CTRL_FMT+1:`PCMVS_CTRL_FMT];
  wire [1:0]  pad   = ctrl_q[`PCMVS_CTRL_PAD+1:`PCMVS_CTRL_PAD];
  wire [1:0]  bsel  = ctrl_q[`PCMVS_CTRL_BSEL+1:`PCMVS_CTRL_BSEL];
  wire [2:0]  gain  = ctrl_q[`PCMVS_CTRL_GAIN+2:`PCMVS_CTRL_GAIN];

  // One wait cycle per access; answer at the second edge
  assign req             = avs_read | avs_write;
  assign acc             = req & ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_ctrl = acc & avs_write & (avs_address == `PCMVS_REG_CTRL);
  assign wr_tx   = acc & avs_write & (avs_address == `PCMVS_REG_TXDATA);
  assign rd_rx   = acc & avs_read & (avs_address == `PCMVS_REG_RXDATA);

  // Handshake phase
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data prepared during the wait cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      if (avs_address == `PCMVS_REG_CTRL) begin
        avs_readdata <= {16'h0000, ctrl_q};
      end else if (avs_address == `PCMVS_REG_TXDATA) begin
        avs_readdata <= {16'h0000, txdata_q};
      end else if (avs_address == `PCMVS_REG_RXDATA) begin
        avs_readdata <= {16'h0000, rxdata_q};
      end else if (avs_address == `PCMVS_REG_STATUS) begin
        avs_readdata <= {16'h0000, frames_q, 6'h00, tx_taken_q, rx_full_q};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  // Control and transmit words, byte lanes honoured
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= `PCMVS_CTRL_RST;
      txdata_q <= `PCMVS_TXDATA_RST;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        ctrl_q[7:0] <= avs_writedata[7:0];       // [R01] [R05] [R06]
      end
      if (wr_ctrl && avs_byteenable[1]) begin
        ctrl_q[15:8] <= avs_writedata[15:8];     // [R09] [R08]
      end
      if (wr_tx && avs_byteenable[0]) begin
        txdata_q[7:0] <= avs_writedata[7:0];
      end
      if (wr_tx && avs_byteenable[1]) begin
        txdata_q[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and clock source selection
  // ----------------------------------------------------------------
  wire [2:0] pins_s;
  wire       gen_bclk;
  reg        fs_gen_q;
  reg        bclk_prev_q;
  reg        fs_prev_q;
  wire       bclk_lvl;
  wire       fs_lvl;
  wire       b_rise;
  wire       b_fall;
  wire       start;

  pcmvs_sync #(
    .W (3)
  ) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({pcm_rx, frame_pulse_i, pcm_bclk_i}),
    .q      (pins_s)
  );

  pcmvs_bclk_gen u_bclk (
    .clock  (clock),
    .arst_n (arst_n),
    .run    (en & mst),
    .sel    (bsel),
    .bclk_q (gen_bclk)
  );

  // Own clocks in master role, codec clocks in slave role
  assign bclk_lvl = mst ? gen_bclk : pins_s[0];            // [R01] [R11]
  assign fs_lvl   = mst ? fs_gen_q : pins_s[1];            // [R01] [R11]

  assign pcm_bclk_o     = gen_bclk;
  assign pcm_bclk_oe    = en & mst;                         // [R01]
  assign frame_pulse_o  = fs_gen_q;
  assign frame_pulse_oe = en & mst;                         // [R01]

  // Edge history of the selected clock and frame pulse
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bclk_prev_q <= 1'b0;
      fs_prev_q   <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_lvl;
      fs_prev_q   <= fs_lvl;
    end
  end

  assign b_rise = en & bclk_lvl & ~bclk_prev_q;
  assign b_fall = en & ~bclk_lvl & bclk_prev_q;

  // Slot begins on the framing edge chosen by software
  assign start = en & (lng ? (fs_lvl & ~fs_prev_q)        // [R03] [R02]
                           : (~fs_lvl & fs_prev_q));      // [R04] [R02]

  // ----------------------------------------------------------------
  // Sample formatting
  // ----------------------------------------------------------------
  reg [15:0] tx_word;
  reg [4:0]  slot_len;

  // Place the sample in its slot word and fill spare bits
  always @* begin
    tx_word  = txdata_q;
    slot_len = 5'd16;
    if (fmt == `PCMVS_FMT_8) begin                          // [R06]
      if (pad == `PCMVS_PAD_NONE) begin
        tx_word  = {8'h00, txdata_q[7:0]};
        slot_len = 5'd8;
      end else if (pad == `PCMVS_PAD_SIGN) begin
        tx_word = {{8{txdata_q[7]}}, txdata_q[7:0]};      // [R07] [R16]
      end else begin
        tx_word = {txdata_q[7:0], 8'h00};                  // [R07]
      end
    end else if (fmt == `PCMVS_FMT_13) begin                // [R06]
      if (pad == `PCMVS_PAD_NONE) begin
        tx_word  = {3'h0, txdata_q[12:0]};
        slot_len = 5'd13;
      end else if (pad == `PCMVS_PAD_SIGN) begin
        tx_word = {{3{txdata_q[12]}}, txdata_q[12:0]};    // [R07] [R16]
      end else if (pad == `PCMVS_PAD_ZERO) begin
        tx_word = {txdata_q[12:0], 3'h0};                  // [R07]
      end else begin
        tx_word = {txdata_q[12:0], gain};                  // [R08]
      end
    end
  end

  // ----------------------------------------------------------------
  // Master frame pulse generator
  // ----------------------------------------------------------------
  reg  [5:0]  fcnt_q;
  reg  [31:0] fr_bits;
  wire        fr_last;

  // Bit clocks per 8 kHz frame at the chosen rate
  always @* begin
    case (bsel)
      2'h0:    fr_bits = `PCMVS_FBITS0;
      2'h1:    fr_bits = `PCMVS_FBITS1;
      2'h2:    fr_bits = `PCMVS_FBITS2;
      default: fr_bits = `PCMVS_FBITS3;
    endcase
  end

  assign fr_last = ({26'h0, fcnt_q} == fr_bits - 32'h1);

  // Count bit clocks and shape the pulse just after each rise
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fcnt_q   <= 6'h00;
      fs_gen_q <= 1'b0;
    end else if (!(en & mst)) begin
      fcnt_q   <= 6'h00;
      fs_gen_q <= 1'b0;
    end else if (b_rise) begin
      fcnt_q <= fr_last ? 6'h00 : fcnt_q + 6'h01;           // [R10] [R09]
      if (lng) begin
        // High over the slot, rising as the frame opens
        fs_gen_q <= fr_last | ({1'b0, fcnt_q} + 7'h01 < {2'h0, slot_len}); // [R15] [R03]
      end else begin
        // One bit wide, falling as the frame opens
        fs_gen_q <= ({26'h0, fcnt_q} == fr_bits - 32'h2);   // [R15] [R04]
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  reg [15:0] tx_sh_q;
  reg [4:0]  tx_cnt_q;

  // Load at slot start, then one bit per bit clock rise
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh_q  <= 16'h0000;
      tx_cnt_q <= 5'h00;
    end else if (!en) begin
      tx_sh_q  <= 16'h0000;
      tx_cnt_q <= 5'h00;
    end else if (start) begin
      tx_sh_q  <= tx_word << (5'd16 - slot_len);            // [R16] [R12]
      tx_cnt_q <= slot_len;
    end else if (b_rise && tx_cnt_q != 5'h00) begin
      tx_sh_q  <= {tx_sh_q[14:0], 1'b0};                    // [R13] [R16]
      tx_cnt_q <= tx_cnt_q - 5'h01;
    end
  end

  assign pcm_tx = (tx_cnt_q != 5'h00) & tx_sh_q[15];      // [R13]

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  reg [15:0] rx_sh_q;
  reg [4:0]  rx_cnt_q;
  wire       rx_done;

  assign rx_done = b_fall & (rx_cnt_q == 5'h01);

  // Sample incoming bits on bit clock fall, most significant first
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_sh_q  <= 16'h0000;
      rx_cnt_q <= 5'h00;
      rxdata_q <= 16'h0000;
    end else if (!en) begin
      rx_cnt_q <= 5'h00;
    end else if (start) begin
      rx_sh_q  <= 16'h0000;
      rx_cnt_q <= slot_len;                                 // [R12]
    end else if (b_fall && rx_cnt_q != 5'h00) begin
      rx_sh_q  <= {rx_sh_q[14:0], pins_s[2]};               // [R14] [R16]
      rx_cnt_q <= rx_cnt_q - 5'h01;
      if (rx_done) begin
        rxdata_q <= {rx_sh_q[14:0], pins_s[2]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_full_q  <= 1'b0;
      tx_taken_q <= 1'b0;
      frames_q   <= 8'h00;
    end else begin
      if (rx_done) begin
        rx_full_q <= 1'b1;
      end else if (rd_rx) begin
        rx_full_q <= 1'b0;
      end
      if (start) begin
        tx_taken_q <= 1'b1;
      end else if (wr_tx) begin
        tx_taken_q <= 1'b0;
      end
      if (start) begin
        frames_q <= frames_q + 8'h01;                       // [R02]
      end
    end
  end

endmodule

// file: sim/pcmvs_port_chk.sv
// Checker for the PCM voice port, watching its top-level ports only.
// Assumes it is bound to pcmvs_port by the bind at the foot of this file.
`timescale 1ns/1ps

module pcmvs_port_chk (
  input wire        clock,           // System clock
  input wire        arst_n,          // Async reset, active low
  input wire [2:0]  avs_address,     // Word address
  input wire        avs_read,        // Read request
  input wire        avs_write,       // Write request
  input wire [31:0] avs_readdata,    // Read data
  input wire        avs_waitrequest, // Stall request
  input wire        pcm_bclk_o,      // Generated bit clock
  input wire        pcm_bclk_oe,     // Bit clock drive enable
  input wire        frame_pulse_o,   // Generated frame pulse
  input wire        frame_pulse_oe,  // Frame pulse drive enable
  input wire        pcm_tx           // Data to codec
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire req = avs_read | avs_write;

  a_wait_first:
    assert property ($rose(req) |-> avs_waitrequest) else $error("new request not stalled");
  a_one_wait:
    assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("more than one wait");
  a_idle_nowait:
    assert property (!req |-> !avs_waitrequest) else $error("stall without request");
  a_upper_zero:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
  a_unmapped_zero:
    assert property (avs_read && !avs_waitrequest && avs_address[2] |-> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
  a_read_hold:
    assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  a_role_pair:
    assert property (pcm_bclk_oe == frame_pulse_oe) else $error("drive enables differ");
  a_pulse_rise:
    assert property (frame_pulse_oe && $rose(frame_pulse_o) |-> pcm_bclk_o && !$past(pcm_bclk_o, 4))
      else $error("frame pulse not after bit clock rise");
  a_tx_launch:
    assert property (pcm_bclk_oe && $changed(pcm_tx) && !$past(avs_write) && !$past(avs_write, 2)
      |-> pcm_bclk_o && !$past(pcm_bclk_o, 6)) else $error("data not launched after rise");
endmodule

bind pcmvs_port pcmvs_port_chk pcmvs_port_chk_inst (.clock, .arst_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .pcm_bclk_o, .pcm_bclk_oe, .frame_pulse_o, .frame_pulse_oe, .pcm_tx);

// file: sim/pcmvs_codec_model.sv
// Codec model: makes slave-role clocks and swaps one slot per frame.
// Assumes the bench resolves the shared clock and pulse wires.
`timescale 1ns/1ps

module pcmvs_codec_model (
  input  wire        bclk_w,      // Resolved bit clock
  input  wire        fp_w,        // Resolved frame pulse
  input  wire        tx,          // Data from the port
  input  wire        gen,         // Make clocks, port is slave
  input  wire        lng,         // Long framing
  input  wire [15:0] word,        // Sample to send
  output reg         rx = 1'b0,   // Data to the port
  output reg         cb = 1'b0,   // Bit clock made here
  output reg         cf = 1'b0,   // Frame pulse made here
  output reg  [15:0] got = 0,     // Last slot seen
  output reg  [7:0]  cnt = 0      // Slots completed
);
  integer k;
  integer j;

  // ----------------------------------------------------------------
  // Slave clocks: 200 ns bit clock, still between frames
  // ----------------------------------------------------------------
  always begin
    wait (gen);
    #5; // Keep pin edges clear of system clock edges
    cf = !lng;
    for (j = 0; j < 19; j++) begin
      cb = 1'b1;
      #10 if (j == 1) cf = lng; // Pulse edge just after the rise
      #90 cb = 1'b0;
      #100;
    end
    cf = 1'b0;
    #1995;
  end

  // ----------------------------------------------------------------
  // Slot exchange from the framing edge, top bit first
  // ----------------------------------------------------------------
  always @(fp_w) if (fp_w === lng) begin
    for (k = 15; k >= 0; k--) begin
      rx = word[k]; // Held across the sampling fall
      @(negedge bclk_w);
      if (gen) #75; // Port answers a few clocks after the pin moves
      got[k] = tx;
      @(posedge bclk_w);
    end
    rx = ~rx; // Released line does not keep its value
    cnt = cnt + 8'h01;
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench for pcmvs_port with a codec model on the far side.
// Assumes pcmvs_defines.vh on the include path.
`timescale 1ns/1ps
`include "pcmvs_defines.vh"
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end

module testbench;
  reg         clock = 0, arst_n = 0, avs_read = 0, avs_write = 0, gen = 0, lng = 0, bq = 0, fq = 0;
  reg  [2:0]  avs_address = 0, gn;
  reg  [3:0]  avs_byteenable = 0;
  reg  [31:0] avs_writedata = 0, q;
  reg  [15:0] mw = 0, s, ctl;
  reg  [20:0] e;
  reg  [7:0]  n, fc;
  reg  [4:0]  cs [0:8] = '{5'h03, 5'h0E, 5'h00, 5'h11, 5'h09, 5'h0A, 5'h0D, 5'h04, 5'h07};
  integer     hf [0:3] = '{`PCMVS_HALF0, `PCMVS_HALF1, `PCMVS_HALF2, `PCMVS_HALF3};
  integer     failures = 0, checked = 0, seed = 62, cyc = 0, bcnt = 0, bper = 0, fcnt = 0, fper = 0, i;
  wire [31:0] avs_readdata;
  wire [15:0] got;
  wire [7:0]  cnt;
  wire        avs_waitrequest, pcm_bclk_o, pcm_bclk_oe, frame_pulse_o, frame_pulse_oe, pcm_tx, rx, cb, cf;
  wire        bclk_w = pcm_bclk_oe ? pcm_bclk_o : cb;
  wire        fp_w = frame_pulse_oe ? frame_pulse_o : cf;

  initial forever #12.5 clock = ~clock;

  pcmvs_port pcmvs_port_inst (.clock, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pcm_bclk_i(bclk_w), .pcm_bclk_o, .pcm_bclk_oe,
    .frame_pulse_i(fp_w), .frame_pulse_o, .frame_pulse_oe, .pcm_tx, .pcm_rx(rx));
  pcmvs_codec_model pcmvs_codec_model_inst (.bclk_w, .fp_w, .tx(pcm_tx), .gen, .lng, .word(mw), .rx, .cb,
    .cf, .got, .cnt);

  // ----------------------------------------------------------------
  // Period meters and timeout
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    bq <= pcm_bclk_o;
    fq <= frame_pulse_o;
    bcnt <= (pcm_bclk_o && !bq) ? 1 : bcnt + 1;
    fcnt <= (frame_pulse_o && !fq) ? 1 : fcnt + 1;
    if (pcm_bclk_o && !bq) bper <= bcnt;
    if (frame_pulse_o && !fq) fper <= fcnt;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      complete_run;
    end
  end

  // Expected slot as {length, left-aligned bits}
  function [20:0] slot(input [1:0] f, input [1:0] p, input [15:0] x, input [2:0] g);
    if (f[1]) slot = {5'h10, x};
    else if (f == 2'h0) case (p)
      2'h0: slot = {5'h08, x[7:0], 8'h00};
      2'h1: slot = {5'h10, {8{x[7]}}, x[7:0]};
      default: slot = {5'h10, x[7:0], 8'h00};
    endcase
    else case (p)
      2'h0: slot = {5'h0D, x[12:0], 3'h0};
      2'h1: slot = {5'h10, {3{x[12]}}, x[12:0]};
      2'h2: slot = {5'h10, x[12:0], 3'h0};
      default: slot = {5'h10, x[12:0], g};
    endcase
  endfunction

  // Avalon-MM transfer, held until waitrequest is seen low
  task bus(input w, input [2:0] a, input [31:0] d, input [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task rd(input [2:0] a, input [31:0] x);
    bus(1'b0, a, 32'h00000000, 4'hF);
    `CHK("register", x, q)
  endtask

  task complete_run;
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rd(`PCMVS_REG_CTRL, 32'h00000000);
    rd(`PCMVS_REG_STATUS, 32'h00000000);
    bus(1'b1, 3'h6, 32'h0000FFFF, 4'hF);
    rd(3'h6, 32'h00000000);
    bus(1'b1, `PCMVS_REG_TXDATA, 32'h0000ABCD, 4'h3);
    bus(1'b1, `PCMVS_REG_TXDATA, 32'h00001234, 4'h2);
    rd(`PCMVS_REG_TXDATA, 32'h000012CD);
    // Master bit clock rates, fastest first
    for (i = 3; i >= 0; i--) begin
      bus(1'b1, `PCMVS_REG_CTRL, 32'h00000007 | (i << 8), 4'hF);
      repeat (6 * hf[i]) @(posedge clock);
      `CHK("bit clock period", 2 * hf[i], bper)
    end
    // Slot formats, master then slave role
    for (i = 0; i < 9; i++) begin
      s = $random(seed);
      gn = $random(seed);
      mw <= $random(seed);
      gen <= (i > 3);
      lng <= cs[i][0];
      ctl = {1'b0, gn, 2'h0, 2'h3, cs[i][2:1], cs[i][4:3], 1'b0, cs[i][0], i < 4, 1'b1};
      bus(1'b1, `PCMVS_REG_TXDATA, {16'h0000, s}, 4'hF);
      bus(1'b1, `PCMVS_REG_CTRL, {16'h0000, ctl}, 4'hF);
      n = cnt + ((i < 4) ? 8'h02 : 8'h03);
      wait (cnt == n);
      @(posedge clock);
      e = slot(cs[i][4:3], cs[i][2:1], s, gn);
      `CHK("tx slot", e[15:0], got)
      bus(1'b0, `PCMVS_REG_STATUS, 32'h00000000, 4'hF);
      `CHK("status flags", 2'h3, q[1:0])
      if (i > 0 && i < 4) `CHK("frame count", fc + 8'h02, q[15:8])
      fc = q[15:8];
      rd(`PCMVS_REG_RXDATA, mw >> (5'h10 - e[20:16]));
      bus(1'b0, `PCMVS_REG_STATUS, 32'h00000000, 4'hF);
      `CHK("rx flag cleared", 1'b0, q[0])
      if (i == 3) `CHK("frame period", `PCMVS_FBITS3 * 2 * `PCMVS_HALF3, fper)
    end
    complete_run;
  end
endmodule
